// *** include/adr_pkg.sv ***
// Constants for the daisy-chain result read-out block.
// Assumes one 20 MHz clock; pins are synchronised inside the block.
`default_nettype none

package adr_pkg;

   ////////////////////////////////////////////////////////////////
   // Clock
   localparam int CLK_HZ            = 20_000_000;

   ////////////////////////////////////////////////////////////////
   // Configuration word layout
   localparam int        CFG_W          = 12;
   localparam logic [11:0] CFG_RESET    = 12'hFFF;
   localparam int        BIT_SOFT_RESET = 0;
   localparam int        BIT_TAG_EN     = 1;
   localparam int        BIT_CHAIN_EN   = 5;
   localparam int        BIT_EOC_POL    = 7;
   localparam int        BIT_AUTO_CH    = 11;

   ////////////////////////////////////////////////////////////////
   // Result and output word layout
   localparam int RES_W     = 12;
   localparam int PAD_W     = 4;
   localparam int TAIL_W    = 7;
   localparam int FIFO_W    = 13;
   localparam int FIFO_DEPTH = 8;
   localparam int SHREG_W   = 24;
   localparam int WORD_PLAIN = 16;
   localparam int WORD_TAG  = 24;
   localparam int TAP_PLAIN = SHREG_W - WORD_PLAIN;

   ////////////////////////////////////////////////////////////////
   // Clocks per read, by mode
   localparam int CLKS_REG_PLAIN = 12;
   localparam int CLKS_REG_TAG   = 17;
   localparam int CLKS_CHN_PLAIN = 16;
   localparam int CLKS_CHN_TAG   = 24;

   ////////////////////////////////////////////////////////////////
   // Serial control states
   typedef enum logic {
      ST_IDLE,
      ST_SHIFT
   } adr_state_t;

endpackage : adr_pkg

`default_nettype wire

// *** rtl/adr_fifo.sv ***
// Result FIFO between the converter core and the read-out shifter.
// Assumes writer and reader share one clock; read data is registered.
`default_nettype none

module adr_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,      // System clock
   input  wire logic             i_rst,      // Sync reset, high
   input  wire logic             i_wr_valid, // Write offered
   input  wire logic [WIDTH-1:0] i_wr_data,  // Write word
   output logic                  o_wr_ready, // Space free
   output logic                  o_rd_valid, // Head word present
   output logic      [WIDTH-1:0] o_rd_data,  // Head word
   input  wire logic             i_rd_ready  // Head consumed
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      cnt_reg;
   logic [AW:0]      cnt_next;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             wr_fire;
   logic             mem_pop;

   ////////////////////////////////////////////////////////////////
   // Handshakes; the output stage refills when empty or drained
   assign wr_fire  = i_wr_valid & o_wr_ready;
   assign mem_pop  = (cnt_reg != '0) & (~out_valid_reg | i_rd_ready);
   assign cnt_next = cnt_reg + (AW+1)'(wr_fire) - (AW+1)'(mem_pop);

   // Storage array, no reset needed
   always_ff @(posedge i_clk) begin
      if (wr_fire) begin
         mem[wr_ptr_reg] <= i_wr_data;
      end
   end

   // Pointers, count and registered ready
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
         o_wr_ready <= 1'b1;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(wr_fire);
         rd_ptr_reg <= rd_ptr_reg + AW'(mem_pop);
         cnt_reg    <= cnt_next;
         o_wr_ready <= (cnt_next != (AW+1)'(DEPTH));
      end
   end

   // Registered head word
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end else if (mem_pop) begin
         out_valid_reg <= 1'b1;
         out_data_reg  <= mem[rd_ptr_reg];
      end else if (i_rd_ready) begin
         out_valid_reg <= 1'b0;
      end
   end

   assign o_rd_valid = out_valid_reg;
   assign o_rd_data  = out_data_reg;

endmodule : adr_fifo

`default_nettype wire

// *** rtl/adr_readout.sv ***
// Serial result read-out with daisy-chain pass-through.
// Assumes host drives chip select and serial clock asynchronously to
// the 20 MHz system clock; the core delivers results on that clock.
`default_nettype none

// Summary of operation
// - Chain bit cleared turns the status pin into the chain data input.
// - Chain input reaches serial out 16 clocks later, 24 with tag.
// - First word after select fall is own 16-bit conversion data.
// - Later words in one select-low frame carry upstream data.
// - Without upstream input, own data repeats every further word.
// - Select toggled between words reloads own result each word.
// - No new conversion: previous result sent, upstream still passed.
// - Clocks per read 12/17+ regular, 16/24 chain, tag then zeros.
// - Internal reset combines power-on and software reset bit.
// - Any reset loads every configuration bit with one.
// - First serial frame after reset sends all ones.
// - Any reset returns the control machine to its idle state.
// - Bit 5 zero selects chain input, one keeps status output.
// - Tag enable puts channel bit at the 17th clock.
// - Result MSB first, four zeros, tag, zeros; high-Z at select rise.
module adr_readout (
   input  wire logic        I_CLK,          // 20 MHz system clock
   input  wire logic        I_RST_N,        // Power-on reset, sync, low
   input  wire logic        I_CS_N,         // Chip select pin
   input  wire logic        I_SCLK,         // Serial clock pin
   input  wire logic        I_PIN10,        // Status pin, input side
   output logic             O_PIN10,        // Status pin, output side
   output logic             O_PIN10_OE,     // Status pin driven
   output logic             O_SDO,          // Serial result out
   output logic             O_SDO_OE,       // Serial out driven
   input  wire logic        I_CFG_WR,       // Config word write strobe
   input  wire logic [11:0] I_CFG_DATA,     // Config word to write
   output logic      [11:0] O_CONFIG_WORD,  // Current config word
   input  wire logic        I_RES_VALID,    // Core result offered
   input  wire logic [11:0] I_RES_DATA,     // Core result code
   input  wire logic        I_RES_CH,       // Core result channel
   output logic             O_RES_READY,    // Result FIFO has room
   output logic             O_RESET_ACTIVE, // Software reset pulse asserted
   output logic      [7:0]  O_WORD_COUNT    // Words done this frame
);

   ////////////////////////////////////////////////////////////////
   // Declarations
   localparam int SW = adr_pkg::SHREG_W;
   localparam int FW = adr_pkg::FIFO_W;

   logic                 soft_rst_reg;
   logic                 rst_all;
   logic [11:0]          cfg_reg;
   logic                 cs_s1_reg;
   logic                 cs_s2_reg;
   logic                 cs_s3_reg;
   logic                 sclk_s1_reg;
   logic                 sclk_s2_reg;
   logic                 sclk_s3_reg;
   logic                 pin_s1_reg;
   logic                 pin_s2_reg;
   logic                 cs_fall;
   logic                 cs_rise;
   logic                 sclk_fall;
   logic                 shift_en;
   adr_pkg::adr_state_t  state_reg;
   adr_pkg::adr_state_t  state_next;
   logic [SW-1:0]        shreg_reg;
   logic [SW-1:0]        shreg_next;
   logic [SW-1:0]        shifted;
   logic [SW-1:0]        own_word;
   logic                 chain_en;
   logic                 tag_en;
   logic                 in_bit;
   logic                 first_frame_reg;
   logic [11:0]          last_res_reg;
   logic                 last_ch_reg;
   logic [11:0]          load_res;
   logic                 load_ch;
   logic                 fifo_valid;
   logic [FW-1:0]        fifo_data;
   logic                 fifo_pop;
   logic                 fifo_wr_ready;
   logic                 sdo_oe_reg;
   logic                 pin_out_reg;
   logic [4:0]           bit_cnt_reg;
   logic [4:0]           word_len;
   logic                 word_end;
   logic [7:0]           word_cnt_reg;

   ////////////////////////////////////////////////////////////////
   // Functions

   // Output word: result MSB first, pad, tag, zero tail
   function automatic logic [SW-1:0] build_word(
      input logic [11:0] res,
      input logic        ch,
      input logic        tag_on
   );
      build_word = {res, adr_pkg::PAD_W'(0), ch & tag_on,
                    adr_pkg::TAIL_W'(0)};
   endfunction : build_word

   // Word length in serial clocks for the current mode
   function automatic logic [4:0] word_clocks(input logic tag_on);
      word_clocks = tag_on ? 5'(adr_pkg::WORD_TAG) : 5'(adr_pkg::WORD_PLAIN);
   endfunction : word_clocks

   ////////////////////////////////////////////////////////////////
   // Reset combination

   // Either power-on or software reset clears the block
   assign rst_all = ~I_RST_N | soft_rst_reg;

   // Software reset pulse; power-on clears it, and it falls again when the zero write ends
   // The pulse lasts one cycle unless the host keeps writing zero
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= I_CFG_WR
                         & ~I_CFG_DATA[adr_pkg::BIT_SOFT_RESET];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Configuration word

   // All ones after any reset; the reset bit writes back as one
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         cfg_reg <= adr_pkg::CFG_RESET;
      end else if (I_CFG_WR) begin
         cfg_reg <= I_CFG_DATA;
      end
   end

   // Bit 5 low means chain mode; auto channel has no effect here
   assign chain_en = ~cfg_reg[adr_pkg::BIT_CHAIN_EN];
   assign tag_en   = cfg_reg[adr_pkg::BIT_TAG_EN];

   ////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Two stages per pin; third stage only feeds edge detection
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         cs_s1_reg   <= 1'b1;
         cs_s2_reg   <= 1'b1;
         cs_s3_reg   <= 1'b1;
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_s3_reg <= 1'b0;
         pin_s1_reg  <= 1'b0;
         pin_s2_reg  <= 1'b0;
      end else begin
         cs_s1_reg   <= I_CS_N;
         cs_s2_reg   <= cs_s1_reg;
         cs_s3_reg   <= cs_s2_reg;
         sclk_s1_reg <= I_SCLK;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
         pin_s1_reg  <= I_PIN10;
         pin_s2_reg  <= pin_s1_reg;
      end
   end

   // Edges seen after synchronisation; host clock must stay well
   // below a quarter of the system clock for these to be caught
   assign cs_fall   = cs_s3_reg & ~cs_s2_reg;
   assign cs_rise   = ~cs_s3_reg & cs_s2_reg;
   assign sclk_fall = sclk_s3_reg & ~sclk_s2_reg & ~cs_s2_reg;

   // Shifting only counts inside a frame the machine has opened
   assign shift_en  = sclk_fall & (state_reg == adr_pkg::ST_SHIFT);

   ////////////////////////////////////////////////////////////////
   // Result buffering

   // Channel bit rides above the code so the tag stays paired
   adr_fifo #(
      .WIDTH (adr_pkg::FIFO_W),
      .DEPTH (adr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk      (I_CLK),
      .i_rst      (rst_all),
      .i_wr_valid (I_RES_VALID),
      .i_wr_data  ({I_RES_CH, I_RES_DATA}),
      .o_wr_ready (fifo_wr_ready),
      .o_rd_valid (fifo_valid),
      .o_rd_data  (fifo_data),
      .i_rd_ready (fifo_pop)
   );

   // A fresh result is taken only at select fall, so the FIFO
   // fills and stalls the core while the host is not reading
   assign fifo_pop = cs_fall & fifo_valid;
   assign load_res = fifo_valid ? fifo_data[11:0] : last_res_reg;
   assign load_ch  = fifo_valid ? fifo_data[12] : last_ch_reg;

   // Remember the last result for frames with no new conversion
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         last_res_reg <= '0;
         last_ch_reg  <= 1'b0;
      end else if (fifo_pop) begin
         last_res_reg <= fifo_data[11:0];
         last_ch_reg  <= fifo_data[12];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control state machine

   // Idle until select falls, shifting until it rises
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         adr_pkg::ST_IDLE: begin
            if (cs_fall) begin
               state_next = adr_pkg::ST_SHIFT;
            end
         end
         adr_pkg::ST_SHIFT: begin
            if (cs_rise) begin
               state_next = adr_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = adr_pkg::ST_IDLE;
         end
      endcase
   end

   // Power-on state after any reset
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         state_reg <= adr_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Output shift register

   // Own word; the frame right after a reset sends ones instead
   assign own_word = first_frame_reg ? {SW{1'b1}}
                                     : build_word(load_res, load_ch, tag_en);

   // Chain mode takes the upstream pin, regular mode recirculates
   // its own word so a lone converter repeats its result
   assign in_bit = chain_en ? pin_s2_reg
                            : shreg_reg[SW-1];

   // Tail tap sets the pass-through delay: 16 bits or 24 bits
   assign shifted = {shreg_reg[SW-2:0], 1'b0};

   always_comb begin
      shreg_next = shreg_reg;
      if (cs_fall) begin
         shreg_next = own_word;
      end else if (shift_en) begin
         shreg_next = shifted;
         if (tag_en) begin
            shreg_next[0] = in_bit;
         end else begin
            shreg_next[adr_pkg::TAP_PLAIN] = in_bit;
            shreg_next[adr_pkg::TAP_PLAIN-1:0] = '0;
         end
      end
   end

   // Reset fills with ones so serial out idles high
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         shreg_reg <= {SW{1'b1}};
      end else begin
         shreg_reg <= shreg_next;
      end
   end

   // Ones stay pending until the first frame after reset closes
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         first_frame_reg <= 1'b1;
      end else if (cs_rise && state_reg == adr_pkg::ST_SHIFT) begin
         first_frame_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Word framing counters

   // Word end marks the last clock of a 16 or 24 clock word
   assign word_len = word_clocks(tag_en);
   assign word_end = sclk_fall && (bit_cnt_reg == word_len - 5'd1);

   // Bits within the current word and words done in the frame
   always_ff @(posedge I_CLK) begin
      if (rst_all || cs_fall) begin
         bit_cnt_reg  <= '0;
         word_cnt_reg <= '0;
      end else if (shift_en) begin
         bit_cnt_reg  <= word_end ? 5'd0 : bit_cnt_reg + 5'd1;
         word_cnt_reg <= word_cnt_reg + 8'(word_end);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pin drivers

   // Serial out driven only while selected; high-Z at select rise
   // Release lags the pin by the synchroniser, about three clocks
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         sdo_oe_reg <= 1'b0;
      end else begin
         sdo_oe_reg <= (state_next == adr_pkg::ST_SHIFT);
      end
   end

   // Status output: result waiting, polarity from bit 7
   always_ff @(posedge I_CLK) begin
      if (rst_all) begin
         pin_out_reg <= 1'b1;
      end else begin
         pin_out_reg <= fifo_valid ^ cfg_reg[adr_pkg::BIT_EOC_POL];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops
   assign O_SDO          = shreg_reg[SW-1];
   assign O_SDO_OE       = sdo_oe_reg;
   assign O_PIN10        = pin_out_reg;
   assign O_PIN10_OE     = cfg_reg[adr_pkg::BIT_CHAIN_EN];
   assign O_CONFIG_WORD  = cfg_reg;
   assign O_RES_READY    = fifo_wr_ready;
   assign O_RESET_ACTIVE = soft_rst_reg;
   assign O_WORD_COUNT   = word_cnt_reg;

endmodule : adr_readout

`default_nettype wire

// *** testbench/adr_readout_asserts.sv ***
// Checker for the daisy-chain read-out block, bound to its ports.
// Assumes serial clock halves of at least five system clocks.
`default_nettype none

module adr_chk (
   input wire logic        I_CLK,          // Clock
   input wire logic        I_RST_N,        // Reset, low
   input wire logic        I_CS_N,         // Select
   input wire logic        I_SCLK,         // Serial clock
   input wire logic        I_PIN10,        // Status pin in
   input wire logic        O_PIN10,        // Status pin out
   input wire logic        O_PIN10_OE,     // Status pin driven
   input wire logic        O_SDO,          // Serial out
   input wire logic        O_SDO_OE,       // Serial out driven
   input wire logic        I_CFG_WR,       // Config strobe
   input wire logic [11:0] I_CFG_DATA,     // Config data
   input wire logic [11:0] O_CONFIG_WORD,  // Config word
   input wire logic        I_RES_VALID,    // Result offered
   input wire logic [11:0] I_RES_DATA,     // Result code
   input wire logic        I_RES_CH,       // Result channel
   input wire logic        O_RES_READY,    // FIFO room
   input wire logic        O_RESET_ACTIVE, // Soft reset
   input wire logic [7:0]  O_WORD_COUNT    // Words done
);
   timeunit 1ns;
   timeprecision 1ns;

   logic       sclk_q;
   logic [3:0] fall_age;
   logic [11:0] cfg_q;
   logic [11:0] cfg_qq;
   wire        sclk_fell = sclk_q && !I_SCLK;

   ////////////////////////////////////////////////////////////////
   // Age since the pin clock fell, saturating so it never wraps
   always_ff @(posedge I_CLK) begin
      sclk_q   <= I_SCLK;
      cfg_q    <= O_CONFIG_WORD;
      cfg_qq   <= cfg_q;
      fall_age <= sclk_fell ? 4'h0 : ((fall_age == 4'hF || !I_RST_N) ? 4'hF : fall_age + 4'h1);
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   ////////////////////////////////////////////////////////////////
   // Soft reset request, then pulse, then defaults
   sequence s_soft_req;
      I_CFG_WR && !I_CFG_DATA[0] && !O_RESET_ACTIVE;
   endsequence
   sequence s_soft_rst;
      O_RESET_ACTIVE ##1 (O_CONFIG_WORD == 12'hFFF && O_WORD_COUNT == 8'h00);
   endsequence

   cfg_write_a: assert property (I_CFG_WR && I_CFG_DATA[0] && !O_RESET_ACTIVE
                                 |=> O_CONFIG_WORD == $past(I_CFG_DATA))
      else $error("config word not stored");
   soft_reset_a: assert property (s_soft_req |=> s_soft_rst)
      else $error("soft reset sequence wrong");
   pin_role_a: assert property (O_CONFIG_WORD == cfg_q && cfg_q == cfg_qq
                                |-> O_PIN10_OE == O_CONFIG_WORD[5])
      else $error("status pin role wrong");
   sdo_on_a: assert property ($fell(I_CS_N) |-> ##[1:6] O_SDO_OE)
      else $error("serial out not driven");
   sdo_off_a: assert property ($rose(I_CS_N) |-> ##[1:6] !O_SDO_OE)
      else $error("serial out not released");
   idle_quiet_a: assert property (I_CS_N [*8] |-> !O_SDO_OE)
      else $error("serial out driven while idle");
   sdo_pace_a: assert property (!I_CS_N && O_SDO_OE && $past(O_SDO_OE) && $changed(O_SDO)
                                |-> fall_age <= 4'h6)
      else $error("serial out moved without clock fall");
   word_step_a: assert property ($changed(O_WORD_COUNT) && O_WORD_COUNT != 8'h00
                                 |-> O_WORD_COUNT == $past(O_WORD_COUNT) + 8'h01 && fall_age <= 4'h6)
      else $error("word count step wrong");
   word_clear_a: assert property ($fell(I_CS_N) |-> ##[1:6] O_WORD_COUNT == 8'h00)
      else $error("word count not cleared");
endmodule : adr_chk

bind adr_readout adr_chk u_adr_chk (
   .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_SCLK(I_SCLK),
   .I_PIN10(I_PIN10), .O_PIN10(O_PIN10), .O_PIN10_OE(O_PIN10_OE),
   .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE), .I_CFG_WR(I_CFG_WR), .I_CFG_DATA(I_CFG_DATA),
   .O_CONFIG_WORD(O_CONFIG_WORD), .I_RES_VALID(I_RES_VALID), .I_RES_DATA(I_RES_DATA),
   .I_RES_CH(I_RES_CH), .O_RES_READY(O_RES_READY), .O_RESET_ACTIVE(O_RESET_ACTIVE),
   .O_WORD_COUNT(O_WORD_COUNT)
);

`default_nettype wire

// *** testbench/adr_up_model.sv ***
// Upstream converter in regular mode, feeding the chain input.
// Assumes the host moves the serial clock only while selected.
`default_nettype none

module adr_up_model (
   input  wire logic        i_cs_n, // Shared select
   input  wire logic        i_sclk, // Shared serial clock
   input  wire logic [31:0] i_word, // Words to pass on
   output logic             o_bit   // Chain data
);
   timeunit 1ns;
   timeprecision 1ns;

   logic cs_q;
   logic sclk_q;
   int   falls;

   // One process owns every model variable; edges found against the
   // levels seen at the previous pin change
   initial begin
      {cs_q, sclk_q, o_bit} = 3'b100;
      falls = 0;
      forever begin
         @(i_cs_n or i_sclk);
         if (cs_q && !i_cs_n) begin
            // Frame start shows the first bit, upstream runs regular mode
            falls = 0;
            o_bit = i_word[31];
         end else if (!cs_q && i_cs_n) begin
            // Released line shows the inverse so a stale bit never passes
            o_bit = ~o_bit;
         end else if (!i_cs_n && sclk_q && !i_sclk) begin
            falls = falls + 1;
         end else if (!i_cs_n && !sclk_q && i_sclk) begin
            // Next bit shown on the rise, clear of the sampling fall
            o_bit = i_word[31 - (falls % 32)];
         end
         cs_q   = i_cs_n;
         sclk_q = i_sclk;
      end
   end
endmodule : adr_up_model

`default_nettype wire

// *** testbench/adr_readout_tb_top.sv ***
// Self-checking bench for the daisy-chain read-out block.
// Assumes the checker is bound in and the upstream model drives the chain.
`default_nettype none

module adr_readout_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, rst_n, cs_n, sclk, cfg_wr, res_valid, res_ch, up_bit;
   logic [11:0] cfg_data, res_data, cfg_word;
   logic [31:0] up_word;
   logic [47:0] b;
   logic        pin10, serial_result_out, sdo_oe, pin10_oe, ready, rst_act;
   logic [7:0]  wcnt;
   int          fail_count, checks_done;
   wire         pin10_lvl = pin10_oe ? pin10 : up_bit;

   adr_readout u_adr_readout (
      .I_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
      .I_PIN10(pin10_lvl), .O_PIN10(pin10), .O_PIN10_OE(pin10_oe),
      .O_SDO(serial_result_out), .O_SDO_OE(sdo_oe), .I_CFG_WR(cfg_wr), .I_CFG_DATA(cfg_data),
      .O_CONFIG_WORD(cfg_word), .I_RES_VALID(res_valid), .I_RES_DATA(res_data),
      .I_RES_CH(res_ch), .O_RES_READY(ready), .O_RESET_ACTIVE(rst_act), .O_WORD_COUNT(wcnt)
   );
   adr_up_model u_adr_up_model (.i_cs_n(cs_n), .i_sclk(sclk), .i_word(up_word), .o_bit(up_bit));

   ////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict;
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic cfg(input logic [11:0] v);
      cfg_wr   = 1'b1;
      cfg_data = v;
      tick(1);
      cfg_wr = 1'b0;
      tick(2);
   endtask : cfg

   // Waits for room under a bound; a stuck FIFO ends the run
   task automatic push(input logic [11:0] code, input logic ch);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      if (n == 20) begin
         fail_count++;
         give_verdict();
      end
      res_valid = 1'b1;
      res_data  = code;
      res_ch    = ch;
      tick(1);
      res_valid = 1'b0;
      tick(1);
   endtask : push

   // Host read: sample before each rise, halves slowed to five clocks
   task automatic frame(input int n, input int wl, output logic [47:0] bits);
      bits = '0;
      cs_n = 1'b0;
      tick(6);
      check(48'(sdo_oe), 48'h1);
      for (int i = 0; i < n; i++) begin
         bits = {bits[46:0], serial_result_out};
         sclk = 1'b1;
         tick(5);
         sclk = 1'b0;
         tick(5);
      end
      check(48'(wcnt), 48'(n / wl));
      cs_n = 1'b1;
      tick(6);
      check(48'(sdo_oe), 48'h0);
   endtask : frame

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_n, sclk, cfg_wr, res_valid, res_ch} = '0;
      {cfg_data, res_data, up_word} = '0;
      cs_n = 1'b1;
      fail_count = 0;
      checks_done = 0;
      tick(2);
      rst_n = 1'b1;
      tick(4);
      check(48'(cfg_word), 48'hFFF);
      check(48'({sdo_oe, pin10_oe, ready, wcnt}), 48'h300);
      frame(16, 24, b);
      check(b, 48'hFFFF);
      cfg(12'hFFD);
      for (int k = 1; k <= 9; k++) push(12'(12'h111 * k), k[0]);
      check(48'({ready, pin10}), 48'h0);
      res_valid = 1'b1;
      res_data  = 12'hEEE;
      tick(2);
      res_valid = 1'b0;
      for (int k = 1; k <= 9; k++) begin
         frame(12, 16, b);
         check(b, 48'(12'(12'h111 * k)));
      end
      check(48'(pin10), 48'h1);
      frame(32, 16, b);
      check(b, 48'h9990_9990);
      cfg(12'hF7F);
      check(48'(pin10), 48'h0);
      push(12'h7E1, 1'b1);
      frame(17, 24, b);
      check(b, 48'({12'h7E1, 4'h0, 1'b1}));
      cfg(12'hFDD);
      check(48'(pin10_oe), 48'h0);
      up_word = 32'h5A3C_C3A5;
      push(12'hABC, 1'b0);
      frame(48, 16, b);
      check(b, {12'hABC, 4'h0, up_word});
      for (int k = 0; k < 3; k++) begin
         frame(16, 16, b);
         check(b, 48'hABC0);
      end
      cfg(12'hFDF);
      push(12'h35A, 1'b1);
      frame(48, 24, b);
      check(b, {12'h35A, 4'h0, 1'b1, 7'h00, up_word[31:8]});
      cfg_wr   = 1'b1;
      cfg_data = 12'hFFE;
      tick(1);
      cfg_wr = 1'b0;
      check(48'(rst_act), 48'h1);
      tick(1);
      check(48'(cfg_word), 48'hFFF);
      tick(4);
      check(48'(pin10_oe), 48'h1);
      frame(16, 24, b);
      check(b, 48'hFFFF);
      give_verdict();
   end
endmodule : adr_readout_tb_top

`default_nettype wire
